// ===== logic/aiscan_top.sv
// module: analog input scan sequencer with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module aiscan_top #(
    parameter int CYC_PER_MS = aiscan_pkg::CYC_PER_MS
) (
    input  wire logic                       i_mclk,
    input  wire logic                       i_rst_b,
    input  wire logic [7:0]                 i_awaddr,
    input  wire logic                       i_awvalid,
    output logic                            o_awready,
    input  wire logic [31:0]                i_wdata,
    input  wire logic [3:0]                 i_wstrb,
    input  wire logic                       i_wvalid,
    output logic                            o_wready,
    output logic [1:0]                      o_bresp,
    output logic                            o_bvalid,
    input  wire logic                       i_bready,
    input  wire logic [7:0]                 i_araddr,
    input  wire logic                       i_arvalid,
    output logic                            o_arready,
    output logic [31:0]                     o_rdata,
    output logic [1:0]                      o_rresp,
    output logic                            o_rvalid,
    input  wire logic                       i_rready,
    input  wire logic [aiscan_pkg::DW-1:0]  i_adc_data,
    input  wire logic                       i_open_wire,
    output logic [aiscan_pkg::CH_W-1:0]     o_adc_ch,
    output logic                            o_adc_start,
    output logic                            o_irq
);
    localparam int N  = aiscan_pkg::NUM_CH;
    localparam int CW = aiscan_pkg::CH_W;

    // ===========================================================
    // reset release
    logic rst_s1_r;
    logic rst_n;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // ===========================================================
    // declarations
    logic [31:0]                  ctrl_r;
    logic [31:0]                  cfg_r [N];
    logic [aiscan_pkg::DW-1:0]    data_r [N];
    logic [N-1:0]                 ow_r;
    logic [aiscan_pkg::IRQ_W-1:0] istat_r;
    logic [aiscan_pkg::IRQ_W-1:0] imask_r;
    logic [aiscan_pkg::IRQ_W-1:0] iset;
    logic [aiscan_pkg::IRQ_W-1:0] iclr;
    logic [aiscan_pkg::TOT_W-1:0] acc_r;
    logic [aiscan_pkg::TOT_W-1:0] mtime_r;
    aiscan_pkg::aiscan_state_e    state_r;
    aiscan_pkg::aiscan_state_e    state_nxt;
    logic [CW-1:0]                ch_r;
    logic [N-1:0]                 ch_en;
    logic [N-1:0]                 oc_on;
    logic [N-1:0]                 cjc_on;
    logic [N-1:0]                 ow_hit;
    logic [CW:0]                  seek_from;
    logic                         nxt_found;
    logic [CW-1:0]                nxt_ch;
    logic [2:0]                   cjc_filt;
    logic                         cjc_need;
    logic                         sample;
    logic [aiscan_pkg::MS_W-1:0]  ch_ms;
    logic [aiscan_pkg::MS_W-1:0]  cjc_ms;
    logic [31:0]                  nxt_cfg;
    aiscan_tmr_if                 tmr ();

    // ===========================================================
    // per-channel decode and result capture
    assign sample = (state_r == aiscan_pkg::S_CONV) && tmr.done;

    for (genvar i = 0; i < N; i++) begin : g_ch
        logic [1:0] ty;
        logic [2:0] oc;
        assign ty = cfg_r[i][aiscan_pkg::CF_TYPE +: 2];
        assign oc = cfg_r[i][aiscan_pkg::CF_OC +: 3];
        assign ch_en[i] = cfg_r[i][aiscan_pkg::CF_EN];
        // any response but disable arms detection, except on a current input with R020 set
        assign oc_on[i] = ch_en[i] && (oc != aiscan_pkg::OC_OFF)
            && !((ty == aiscan_pkg::TY_CURR)
            && cfg_r[i][aiscan_pkg::CF_R020]);
        assign cjc_on[i] = ch_en[i] && cfg_r[i][aiscan_pkg::CF_CJC];
        assign ow_hit[i] = sample && (ch_r == CW'(i))
            && oc_on[i] && i_open_wire;

        always_ff @(posedge i_mclk or negedge rst_n) begin
            if (!rst_n) begin
                data_r[i] <= aiscan_pkg::DATA_RST;
            end else if (sample && (ch_r == CW'(i))) begin
                if (ow_hit[i]) begin
                    case (oc)
                        aiscan_pkg::OC_UP: begin
                            data_r[i] <= aiscan_pkg::FS_MAX;
                        end
                        aiscan_pkg::OC_DOWN: begin
                            data_r[i] <= aiscan_pkg::FS_MIN;
                        end
                        aiscan_pkg::OC_ZERO: begin
                            data_r[i] <= aiscan_pkg::ZERO_W;
                        end
                        default: begin
                            data_r[i] <= data_r[i];
                        end
                    endcase
                end else begin
                    data_r[i] <= i_adc_data;
                end
            end
        end

        always_ff @(posedge i_mclk or negedge rst_n) begin
            if (!rst_n) begin
                ow_r[i] <= 1'b0;
            end else if (!oc_on[i]) begin
                ow_r[i] <= 1'b0;
            end else if (sample && (ch_r == CW'(i))) begin
                ow_r[i] <= i_open_wire;
            end
        end
    end

    // ===========================================================
    // next enabled channel and compensation slot
    assign seek_from = (state_r == aiscan_pkg::S_IDLE) ? '0 :
                       ({1'b0, ch_r} + (CW + 1)'(1));

    // disabled channels are never selected
    always_comb begin
        nxt_found = 1'b0;
        nxt_ch    = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (ch_en[i] && ((CW + 1)'(i) >= seek_from)) begin
                nxt_found = 1'b1;
                nxt_ch    = CW'(i);
            end
        end
    end

    // lowest filter index is the slowest setting
    always_comb begin
        cjc_filt = aiscan_pkg::FILT_MAX;
        for (int i = 0; i < N; i++) begin
            if (cjc_on[i]
                && (cfg_r[i][aiscan_pkg::CF_FILT +: 3] < cjc_filt)) begin
                cjc_filt = cfg_r[i][aiscan_pkg::CF_FILT +: 3];
            end
        end
    end

    assign cjc_need = (|cjc_on) && ctrl_r[aiscan_pkg::CT_CJEO];
    assign nxt_cfg  = cfg_r[nxt_ch];

    aiscan_period u_period (
        .i_type     (nxt_cfg[aiscan_pkg::CF_TYPE +: 2]),
        .i_filt     (nxt_cfg[aiscan_pkg::CF_FILT +: 3]),
        .i_oc_on    (oc_on[nxt_ch]),
        .i_cjc_filt (cjc_filt),
        .o_ch_ms    (ch_ms),
        .o_cjc_ms   (cjc_ms)
    );

    aiscan_timer #(.CYC(CYC_PER_MS)) u_timer (
        .i_mclk  (i_mclk),
        .i_rst_n (rst_n),
        .t       (tmr.tmr)
    );

    // ===========================================================
    // scan sequencer
    always_comb begin
        state_nxt = state_r;
        tmr.load  = 1'b0;
        tmr.ms    = ch_ms;
        case (state_r)
            aiscan_pkg::S_IDLE: begin
                if (ctrl_r[aiscan_pkg::CT_RUN] && nxt_found) begin
                    state_nxt = aiscan_pkg::S_CONV;
                    tmr.load  = 1'b1;
                end else if (ctrl_r[aiscan_pkg::CT_RUN] && cjc_need) begin
                    state_nxt = aiscan_pkg::S_CJC;
                    tmr.load  = 1'b1;
                    tmr.ms    = cjc_ms;
                end
            end
            aiscan_pkg::S_CONV: begin
                if (tmr.done) begin
                    if (nxt_found) begin
                        tmr.load = 1'b1;
                    end else if (cjc_need) begin
                        // entered once per scan
                        state_nxt = aiscan_pkg::S_CJC;
                        tmr.load  = 1'b1;
                        tmr.ms    = cjc_ms;
                    end else begin
                        state_nxt = aiscan_pkg::S_END;
                    end
                end
            end
            aiscan_pkg::S_CJC: begin
                if (tmr.done) begin
                    state_nxt = aiscan_pkg::S_END;
                end
            end
            default: begin
                state_nxt = aiscan_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= aiscan_pkg::S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ch_r        <= '0;
            o_adc_ch    <= '0;
            o_adc_start <= 1'b0;
        end else begin
            o_adc_start <= tmr.load && (state_nxt == aiscan_pkg::S_CONV);
            if (tmr.load && (state_nxt == aiscan_pkg::S_CONV)) begin
                ch_r     <= nxt_ch;
                o_adc_ch <= nxt_ch;
            end
        end
    end

    // counts slot ms only; each slot's done cycle and the end and idle cycles are not counted
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r   <= '0;
            mtime_r <= '0;
        end else if (state_r == aiscan_pkg::S_END) begin
            mtime_r <= acc_r;
            acc_r   <= '0;
        end else if (tmr.load) begin
            acc_r <= acc_r + aiscan_pkg::TOT_W'(tmr.ms);
        end
    end

    // ===========================================================
    // AXI4-Lite slave
    logic        aw_v_r;
    logic        w_v_r;
    logic [7:0]  aw_a_r;
    logic [31:0] w_d_r;
    logic [3:0]  w_s_r;
    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        wr_do;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic [31:0] rd_mux;
    logic        rd_ok;
    logic        wr_ok;

    assign aw_take = i_awvalid && o_awready;
    assign w_take  = i_wvalid && o_wready;
    assign ar_take = i_arvalid && o_arready;
    assign wr_do   = aw_v_r && w_v_r && !o_bvalid;
    assign wmask   = {{8{w_s_r[3]}}, {8{w_s_r[2]}},
                      {8{w_s_r[1]}}, {8{w_s_r[0]}}};
    assign wbits   = w_d_r & wmask;
    assign wr_ok   = (aw_a_r < aiscan_pkg::A_DATA0)
        && !(aw_a_r > aiscan_pkg::A_MTIME
             && aw_a_r < aiscan_pkg::A_CFG0)
        && (aw_a_r < aiscan_pkg::A_CFG0 + 8'(4 * N));

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_v_r    <= 1'b0;
            w_v_r     <= 1'b0;
            aw_a_r    <= '0;
            w_d_r     <= '0;
            w_s_r     <= '0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= 2'h0;
        end else begin
            o_awready <= !(aw_take || (aw_v_r && !wr_do));
            o_wready  <= !(w_take || (w_v_r && !wr_do));
            if (aw_take) begin
                aw_v_r <= 1'b1;
                aw_a_r <= {i_awaddr[7:2], 2'h0};
            end else if (wr_do) begin
                aw_v_r <= 1'b0;
            end
            if (w_take) begin
                w_v_r <= 1'b1;
                w_d_r <= i_wdata;
                w_s_r <= i_wstrb;
            end else if (wr_do) begin
                w_v_r <= 1'b0;
            end
            if (wr_do) begin
                o_bvalid <= 1'b1;
                o_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // ===========================================================
    // writable registers
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r  <= aiscan_pkg::CTRL_RST;
            imask_r <= '0;
        end else if (wr_do) begin
            if (aw_a_r == aiscan_pkg::A_CTRL) begin
                ctrl_r <= (ctrl_r & ~wmask) | wbits;
            end
            if (aw_a_r == aiscan_pkg::A_IMASK) begin
                imask_r <= (imask_r & ~wmask[aiscan_pkg::IRQ_W-1:0])
                         | wbits[aiscan_pkg::IRQ_W-1:0];
            end
        end
    end

    // config writes apply at once; a running slot keeps the length it was loaded with
    for (genvar i = 0; i < N; i++) begin : g_cfg
        always_ff @(posedge i_mclk or negedge rst_n) begin
            if (!rst_n) begin
                cfg_r[i] <= aiscan_pkg::CFG_RST;
            end else if (wr_do
                && aw_a_r == aiscan_pkg::A_CFG0 + 8'(4 * i)) begin
                cfg_r[i] <= (cfg_r[i] & ~wmask) | wbits;
            end
        end
    end

    // ===========================================================
    // sticky interrupt status, write one to clear, set wins
    assign iset  = {ow_hit, state_r == aiscan_pkg::S_END};
    assign iclr  = (wr_do && aw_a_r == aiscan_pkg::A_ISTAT) ?
                   wbits[aiscan_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            istat_r <= '0;
            o_irq   <= 1'b0;
        end else begin
            istat_r <= (istat_r & ~iclr) | iset;
            o_irq   <= |(istat_r & imask_r);
        end
    end

    // ===========================================================
    // read path
    always_comb begin
        rd_mux = '0;
        rd_ok  = 1'b1;
        case (i_araddr[7:2])
            aiscan_pkg::A_CTRL[7:2]: begin
                rd_mux = ctrl_r;
            end
            aiscan_pkg::A_STAT[7:2]: begin
                rd_mux[1:0] = state_r;
                rd_mux[aiscan_pkg::ST_OW +: N] = ow_r;
            end
            aiscan_pkg::A_ISTAT[7:2]: begin
                rd_mux[aiscan_pkg::IRQ_W-1:0] = istat_r;
            end
            aiscan_pkg::A_IMASK[7:2]: begin
                rd_mux[aiscan_pkg::IRQ_W-1:0] = imask_r;
            end
            aiscan_pkg::A_MTIME[7:2]: begin
                rd_mux[aiscan_pkg::TOT_W-1:0] = mtime_r;
            end
            default: begin
                rd_ok = 1'b0;
                for (int i = 0; i < N; i++) begin
                    if (i_araddr[7:2] == 6'(aiscan_pkg::A_CFG0[7:2] + i)) begin
                        rd_mux = cfg_r[i];
                        rd_ok  = 1'b1;
                    end
                    if (i_araddr[7:2] == 6'(aiscan_pkg::A_DATA0[7:2] + i)) begin
                        rd_mux[aiscan_pkg::DW-1:0] = data_r[i];
                        rd_ok = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= 2'h0;
        end else begin
            o_arready <= !ar_take && !(o_rvalid && !i_rready);
            if (ar_take) begin
                o_rvalid <= 1'b1;
                o_rdata  <= rd_mux;
                o_rresp  <= rd_ok ? 2'h0 : 2'h2;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end
endmodule : aiscan_top

// ===== pkg/aiscan_pkg.sv
// package: constants and types of the analog input scan sequencer
package aiscan_pkg;
    // ===========================================================
    // sizes and time base
    localparam int NUM_CH     = 4;
    localparam int CH_W       = 2;
    localparam int DW         = 16;
    localparam int MS_W       = 12;
    localparam int TOT_W      = 16;
    localparam int CLK_NS     = 100;
    localparam int MS_NS      = 1_000_000;
    localparam int CYC_PER_MS = MS_NS / CLK_NS;

    // ===========================================================
    // register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_STAT  = 8'h04;
    localparam logic [7:0] A_ISTAT = 8'h08;
    localparam logic [7:0] A_IMASK = 8'h0c;
    localparam logic [7:0] A_MTIME = 8'h10;
    localparam logic [7:0] A_CFG0  = 8'h20;
    localparam logic [7:0] A_DATA0 = 8'h40;

    // ===========================================================
    // field positions
    localparam int CT_RUN  = 0;
    localparam int CT_CJEO = 1;
    localparam int CF_EN   = 0;
    localparam int CF_TYPE = 1;
    localparam int CF_R020 = 3;
    localparam int CF_FILT = 4;
    localparam int CF_CJC  = 7;
    localparam int CF_OC   = 8;
    localparam int IS_DONE = 0;
    localparam int IS_OW   = 1;
    localparam int ST_OW   = 4;
    localparam int IRQ_W   = NUM_CH + 1;

    // ===========================================================
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_RST  = 32'h0000_0000;
    localparam logic [DW-1:0] DATA_RST = 16'h0000;

    // ===========================================================
    // substitute data words on an open input
    localparam logic [DW-1:0] FS_MAX = 16'h7fff;
    localparam logic [DW-1:0] FS_MIN = 16'h8000;
    localparam logic [DW-1:0] ZERO_W = 16'h0000;

    // ===========================================================
    // slot lengths in ms, filter index 0..5 = 10,50,60,250,500,1k Hz
    localparam logic [MS_W-1:0] T_FAST [6] = '{12'h133, 12'h043,
        12'h039, 12'h013, 12'h00d, 12'h00b};
    localparam logic [MS_W-1:0] T_SLOW [6] = '{12'h266, 12'h086,
        12'h072, 12'h026, 12'h01a, 12'h016};
    localparam logic [MS_W-1:0] T_OCD  = 12'h00b;
    localparam logic [2:0]      FILT_MAX = 3'h5;

    // ===========================================================
    // types
    typedef enum logic [1:0] {
        TY_VOLT = 2'h0, TY_CURR = 2'h1, TY_TC = 2'h2, TY_RES = 2'h3
    } aiscan_type_e;
    typedef enum logic [2:0] {
        OC_OFF = 3'h0, OC_UP = 3'h1, OC_DOWN = 3'h2,
        OC_HOLD = 3'h3, OC_ZERO = 3'h4
    } aiscan_oc_e;
    typedef enum logic [1:0] {
        S_IDLE = 2'h0, S_CONV = 2'h1, S_CJC = 2'h3, S_END = 2'h2
    } aiscan_state_e;
endpackage : aiscan_pkg

// ===== pkg/aiscan_tmr_if.sv
// interface: slot timer load and completion
`timescale 1ns/1ps
interface aiscan_tmr_if;
    logic                          load;
    logic [aiscan_pkg::MS_W-1:0]   ms;
    logic                          done;
    modport ctl (output load, output ms, input done);
    modport tmr (input load, input ms, output done);
endinterface : aiscan_tmr_if

// ===== logic/aiscan_timer.sv
// module: millisecond slot timer
`timescale 1ns/1ps
module aiscan_timer #(
    parameter int CYC = aiscan_pkg::CYC_PER_MS
) (
    input  wire logic  i_mclk,
    input  wire logic  i_rst_n,
    aiscan_tmr_if.tmr  t
);
    localparam int PW = $clog2(CYC + 1);
    logic [PW-1:0]                 pre_r;
    logic [aiscan_pkg::MS_W-1:0]   left_r;
    logic                          done_r;

    assign t.done = done_r;

    // a load in the done cycle restarts at once, so slots abut
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_r  <= '0;
            left_r <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (t.load) begin
                pre_r  <= PW'(CYC - 1);
                left_r <= t.ms;
            end else if (left_r != '0) begin
                if (pre_r != '0) begin
                    pre_r <= pre_r - PW'(1);
                end else begin
                    pre_r  <= PW'(CYC - 1);
                    left_r <= left_r - aiscan_pkg::MS_W'(1);
                    done_r <= (left_r == aiscan_pkg::MS_W'(1));
                end
            end
        end
    end
endmodule : aiscan_timer

// ===== logic/aiscan_period.sv
// module: slot length lookup per channel and for compensation
`timescale 1ns/1ps
module aiscan_period (
    input  wire logic [1:0]                    i_type,
    input  wire logic [2:0]                    i_filt,
    input  wire logic                          i_oc_on,
    input  wire logic [2:0]                    i_cjc_filt,
    output logic      [aiscan_pkg::MS_W-1:0]   o_ch_ms,
    output logic      [aiscan_pkg::MS_W-1:0]   o_cjc_ms
);
    logic [2:0] f;
    logic [2:0] cf;
    logic       slow;

    // out-of-range filter codes act as the fastest filter
    assign f  = (i_filt > aiscan_pkg::FILT_MAX) ?
                aiscan_pkg::FILT_MAX : i_filt;
    assign cf = (i_cjc_filt > aiscan_pkg::FILT_MAX) ?
                aiscan_pkg::FILT_MAX : i_cjc_filt;
    // range bits never reach here
    assign slow = (i_type == aiscan_pkg::TY_RES);

    always_comb begin
        o_ch_ms = slow ? aiscan_pkg::T_SLOW[f] :
                         aiscan_pkg::T_FAST[f];
        if (i_oc_on) begin
            o_ch_ms = o_ch_ms + aiscan_pkg::T_OCD;
        end
        o_cjc_ms = aiscan_pkg::T_SLOW[cf];
    end
endmodule : aiscan_period

// ===== bench/aiscan_sensor.sv
// field sensor model: one level on all channels, cuttable wire on ch 0
`timescale 1ns/1ps
module aiscan_sensor (
    input  wire logic [1:0]  i_ch,
    input  wire logic [15:0] i_lvl,
    input  wire logic        i_cut,
    output logic      [15:0] o_data,
    output logic             o_open
);
    assign o_data = i_lvl;
    assign o_open = i_cut && i_ch == 2'h0;
endmodule : aiscan_sensor

// ===== bench/aiscan_checker.sv
// checker: handshake and slot timing at the sequencer's ports
`timescale 1ns/1ps
module aiscan_checker (
    input wire logic       i_mclk,
    input wire logic       i_rst_b,
    input wire logic       i_arvalid,
    input wire logic       i_bready,
    input wire logic       o_arready,
    input wire logic       o_bvalid,
    input wire logic       o_rvalid,
    input wire logic [1:0] o_adc_ch,
    input wire logic       o_adc_start,
    input wire logic       o_irq
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    a_start_gap: assert property (o_adc_start |=> !o_adc_start[*8])
        else $error("slot starts too close");
    a_ch_held: assert property (o_adc_start |=> $stable(o_adc_ch)[*8])
        else $error("channel moved in slot");
    a_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
    a_rd_busy: assert property (o_rvalid |-> !o_arready)
        else $error("read taken while busy");
    a_rd_taken: assert property (i_arvalid && o_arready |=> !o_arready)
        else $error("read ready stayed up");
    a_wr_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write answer dropped");
    a_wr_done: assert property (o_bvalid && i_bready |=> !o_bvalid)
        else $error("write answer repeated");
    a_irq_reset: assert property ($rose(i_rst_b) |-> !o_irq ##1 !o_irq)
        else $error("irq up after reset");
    cover property (o_adc_start && o_adc_ch == 2'h2);
    cover property ($rose(o_irq));
    cover property (o_bvalid && i_bready);
endmodule : aiscan_checker
bind aiscan_top aiscan_checker u_chk (.*);

// ===== bench/aiscan_top_test.sv
// bench: register access and scan timing of the sequencer
`timescale 1ns/1ps
module aiscan_top_test;
    logic        i_mclk, i_rst_b, i_awvalid, i_wvalid, i_bready, cut;
    logic        i_arvalid, i_rready;
    logic [7:0]  i_awaddr, i_araddr;
    logic [31:0] i_wdata;
    logic [3:0]  i_wstrb = 4'hf;
    logic [15:0] lvl, old;
    logic [59:0] r;
    logic [41:0] q [$];
    logic [1:0]  qb [$];
    int          fail_count, checked;
    wire  [31:0] o_rdata;
    wire  [15:0] i_adc_data;
    wire  [1:0]  o_bresp, o_rresp, o_adc_ch;
    wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire         i_open_wire, o_adc_start, o_irq;
    wire         busy = i_awvalid | i_wvalid | i_bready | i_arvalid | i_rready;
    // cfg0, cfg2, ctrl, open+cut, period ms, held+live, data word
    localparam logic [59:0] ROWS [7] = '{60'h051_2710_07d1_0000,
        60'h351_2713_0882_0000, 60'h151_2713_0880_7fff,
        60'h251_2713_0880_8000, 60'h451_2713_0880_0000,
        60'h45b_2711_07d1_0000, 60'h0d1_8530_3a41_0000};
    aiscan_top #(.CYC_PER_MS(10)) dut (.*);
    aiscan_sensor field (.i_ch(o_adc_ch), .i_lvl(lvl), .i_cut(cut),
        .o_data(i_adc_data), .o_open(i_open_wire));
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    task automatic conclude(bit hung);
        fail_count += int'(hung);
        $display("checked %0d failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic chk(logic [41:0] e);
        checked++;
        if (e[33] ? o_rresp !== 2'h2 : {o_rresp, o_rdata} !== e[33:0]) begin
            fail_count++;
            $display("CHECK FAILED reg %h exp %h got %h", e[41:34], e[33:0],
                {o_rresp, o_rdata});
        end
    endtask : chk
    always @(posedge i_mclk)
        if (o_rvalid === 1'b1 && i_rready) chk(q.pop_front());
    task automatic chkb(logic [1:0] e);
        checked++;
        if (o_bresp !== e) begin
            fail_count++;
            $display("CHECK FAILED bresp exp %h got %h", e, o_bresp);
        end
    endtask : chkb
    always @(posedge i_mclk)
        if (o_bvalid === 1'b1 && i_bready) chkb(qb.pop_front());
    // one bus cycle; read expectations queue up for the watcher
    task automatic xfer(bit w, logic [7:0] a, logic [33:0] d);
        if (w) qb.push_back(d[33:32]);
        else q.push_back({a, d});
        {i_awaddr, i_araddr, i_wdata} <= {a, a, d[31:0]};
        {i_awvalid, i_wvalid, i_bready} <= {3{w}};
        {i_arvalid, i_rready} <= {2{!w}};
        for (int n = 0; n < 40; n++) begin
            @(posedge i_mclk);
            if (!busy) break;
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) i_bready <= 1'b0;
            if (o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) i_rready <= 1'b0;
        end
        if (busy) conclude(1'b1);
    endtask : xfer
    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, cut} = '0;
        {i_awaddr, i_araddr, i_wdata} = '0;
        i_rst_b = 1'b0;
        lvl = 16'($urandom(32'hfd34_19b3));
        repeat (3) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_mclk);
        xfer(0, aiscan_pkg::A_CFG0, 34'h0);
        xfer(0, 8'h18, 34'h2_0000_0000);
        xfer(1, 8'h18, 34'h2_0000_0000);
        xfer(1, aiscan_pkg::A_IMASK, 34'h1);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            cut <= r[32];
            xfer(1, aiscan_pkg::A_CFG0, 34'(r[59:48]));
            xfer(1, 8'h28, 34'(r[47:40]));
            xfer(1, aiscan_pkg::A_CTRL, 34'(r[39:36]));
            // new level after the mode is in, so a held word shows
            old = lvl;
            lvl <= 16'($urandom);
            // first completion may mix old and new settings
            repeat (2) begin
                xfer(1, aiscan_pkg::A_ISTAT, 34'h1f);
                for (int n = 0; n < 20000 && o_irq !== 1'b1; n++)
                    @(posedge i_mclk);
                if (o_irq !== 1'b1) conclude(1'b1);
            end
            xfer(0, aiscan_pkg::A_MTIME, 34'(r[31:20]));
            xfer(0, aiscan_pkg::A_DATA0,
                34'(r[17] ? old : r[16] ? lvl : r[15:0]));
            xfer(0, aiscan_pkg::A_ISTAT, 34'({r[33], 1'b1}));
            $display("row %0d done", i);
        end
        conclude(1'b0);
    end
endmodule : aiscan_top_test
